// ==== hw/pmax_pkg.sv ====
// Purpose: constants and types for the page and module address extension
// Assumes: one clock, bytes of 8 bits, 8 pages of 2048 locations
// Notes: module register bits [5:3] name the page, [2:0] the 256-word
//        module within it
package pmax_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PMAX_OFS_W = 11;
  localparam int PMAX_PAGE_W = 3;
  localparam int PMAX_ADDR_W = PMAX_OFS_W + PMAX_PAGE_W;
  localparam int PMAX_PAGES = 8;
  localparam int PMAX_DATA_W = 8;

  // ****************************************************************
  // Field positions in a module select register
  // ****************************************************************
  localparam int PMAX_PAGE_LSB = 3;
  localparam int PMAX_PAGE_MSB = 5;
  localparam int PMAX_MOD_LSB = 0;
  localparam int PMAX_MOD_MSB = 2;

  // ****************************************************************
  // Reset values and the counter step
  // ****************************************************************
  localparam logic [7:0] PMAX_MODSEL_RST = 8'h00;
  localparam logic [2:0] PMAX_PAGE_RST = 3'h0;
  localparam logic [10:0] PMAX_OFS_RST = 11'h000;
  localparam logic [10:0] PMAX_OFS_ONE = 11'h001;

  // ****************************************************************
  // Operations presented by the execution unit
  // ****************************************************************
  typedef enum logic [3:0] {
    PMAX_OP_NONE = 4'h0,
    PMAX_OP_JUMP = 4'h1,
    PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE = 4'h2,
    PMAX_OP_STORE_ACC_TO_DATA_MODULE = 4'h3,
    PMAX_OP_LOAD_ACC_FROM_DATA_MODULE = 4'h4,
    PMAX_OP_STORE_ACC_TO_POINTER_VIA_DATA = 4'h5,
    PMAX_OP_STORE_ACC_TO_POINTER_VIA_PROG = 4'h6,
    PMAX_OP_STORE_ACC_TO_COUNTER_VIA_DATA_MODULE = 4'h7,
    PMAX_OP_STORE_ACC_TO_COUNTER_VIA_PROG = 4'h8,
    PMAX_OP_LOAD_IND_PROG = 4'h9,
    PMAX_OP_LOAD_IND_DATA = 4'hA,
    PMAX_OP_STORE_IND_DATA = 4'hB
  } pmax_op_t;

  // Gray order along the indirect path: idle, access, fetch, latch
  typedef enum logic [1:0] {
    PMAX_ST_IDLE = 2'h0,
    PMAX_ST_ACCESS = 2'h1,
    PMAX_ST_FETCH = 2'h3,
    PMAX_ST_LATCH = 2'h2
  } pmax_state_t;

endpackage

// ==== hw/pmax_core.sv ====
// Purpose: per-page counters and pointers, page extension and fetch
// Assumes: memory answers reads in the same cycle as the read strobe
// Notes: one operation is taken only while ready_out is high
module pmax_core
  import pmax_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic op_valid_in,
  input wire pmax_op_t op_in,
  input wire logic [7:0] acc_in,
  input wire logic [10:0] jump_addr_in,
  input wire logic [7:0] mem_rdata_in,
  output logic ready_out,
  output logic [13:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic fetch_out,
  output logic [7:0] instr_out,
  output logic instr_valid_out,
  output logic [7:0] acc_data_out,
  output logic acc_load_out,
  output logic [7:0] program_module_out,
  output logic [7:0] data_module_out,
  output logic [2:0] fetch_page_extension_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  pmax_state_t state_r, state_nxt;
  logic [7:0] prog_r, prog_nxt, data_r, data_nxt;
  logic [2:0] fext_r, fext_nxt;
  logic [13:0] addr_nxt;
  logic rd_nxt, wr_nxt, fetch_nxt, ivalid_nxt, aload_nxt, ready_nxt;
  logic [7:0] wdata_nxt, instr_nxt, acc_nxt;
  logic [10:0] pc_r [PMAX_PAGES];
  logic [10:0] dp_r [PMAX_PAGES];
  logic [2:0] ppage, dpage;
  logic take;

  assign ppage = prog_r[PMAX_PAGE_MSB:PMAX_PAGE_LSB];
  assign dpage = data_r[PMAX_PAGE_MSB:PMAX_PAGE_LSB];
  assign take = op_valid_in && (state_r == PMAX_ST_IDLE);

  always_comb
  begin
    state_nxt = state_r;
    prog_nxt = prog_r;
    data_nxt = data_r;
    fext_nxt = fext_r;
    addr_nxt = mem_addr_out;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    wdata_nxt = mem_wdata_out;
    fetch_nxt = 1'b0;
    instr_nxt = instr_out;
    ivalid_nxt = 1'b0;
    acc_nxt = acc_data_out;
    aload_nxt = 1'b0;
    case (state_r)
      PMAX_ST_IDLE:
      begin
        if (take)
        begin
          state_nxt = PMAX_ST_FETCH;
          case (op_in)
            PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE:
              prog_nxt = acc_in;
            PMAX_OP_STORE_ACC_TO_DATA_MODULE:
              data_nxt = acc_in;
            PMAX_OP_LOAD_ACC_FROM_DATA_MODULE:
            begin
              acc_nxt = data_r;
              aload_nxt = 1'b1;
            end
            PMAX_OP_LOAD_IND_PROG:
            begin
              addr_nxt = {ppage, dp_r[ppage]};
              rd_nxt = 1'b1;
              state_nxt = PMAX_ST_ACCESS;
            end
            PMAX_OP_LOAD_IND_DATA:
            begin
              addr_nxt = {dpage, dp_r[dpage]};
              rd_nxt = 1'b1;
              state_nxt = PMAX_ST_ACCESS;
            end
            PMAX_OP_STORE_IND_DATA:
            begin
              addr_nxt = {dpage, dp_r[dpage]};
              wr_nxt = 1'b1;
              wdata_nxt = acc_in;
              state_nxt = PMAX_ST_ACCESS;
            end
            default:
              state_nxt = PMAX_ST_FETCH;
          endcase
        end
      end
      PMAX_ST_ACCESS:
      begin
        if (mem_rd_out)
        begin
          acc_nxt = mem_rdata_in;
          aload_nxt = 1'b1;
        end
        state_nxt = PMAX_ST_FETCH;
      end
      PMAX_ST_FETCH:
      begin
        // Fetch still uses the old extension, so one old-page word runs
        addr_nxt = {fext_r, pc_r[fext_r]};
        rd_nxt = 1'b1;
        fetch_nxt = 1'b1;
        fext_nxt = ppage;
        state_nxt = PMAX_ST_LATCH;
      end
      PMAX_ST_LATCH:
      begin
        instr_nxt = mem_rdata_in;
        ivalid_nxt = 1'b1;
        state_nxt = PMAX_ST_IDLE;
      end
      default:
        state_nxt = PMAX_ST_IDLE;
    endcase
    ready_nxt = (state_nxt == PMAX_ST_IDLE);
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r <= PMAX_ST_IDLE;
      prog_r <= PMAX_MODSEL_RST;
      data_r <= PMAX_MODSEL_RST;
      fext_r <= PMAX_PAGE_RST;
      ready_out <= 1'b1;
      mem_addr_out <= 14'h0000;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_wdata_out <= 8'h00;
      fetch_out <= 1'b0;
      instr_out <= 8'h00;
      instr_valid_out <= 1'b0;
      acc_data_out <= 8'h00;
      acc_load_out <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      prog_r <= prog_nxt;
      data_r <= data_nxt;
      fext_r <= fext_nxt;
      ready_out <= ready_nxt;
      mem_addr_out <= addr_nxt;
      mem_rd_out <= rd_nxt;
      mem_wr_out <= wr_nxt;
      mem_wdata_out <= wdata_nxt;
      fetch_out <= fetch_nxt;
      instr_out <= instr_nxt;
      instr_valid_out <= ivalid_nxt;
      acc_data_out <= acc_nxt;
      acc_load_out <= aload_nxt;
    end
  end

  assign program_module_out = prog_r;
  assign data_module_out = data_r;
  assign fetch_page_extension_out = fext_r;

  // ****************************************************************
  // Private counter and pointer of each page
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < PMAX_PAGES; p++)
    begin : g_page
      logic [10:0] pc_nxt, dp_nxt;
      always_comb
      begin
        pc_nxt = pc_r[p];
        dp_nxt = dp_r[p];
        if (take && op_in == PMAX_OP_JUMP && fext_r == 3'(p))
          pc_nxt = jump_addr_in;
        if (take && op_in == PMAX_OP_STORE_ACC_TO_COUNTER_VIA_DATA_MODULE
            && dpage == 3'(p))
          pc_nxt = {data_r[PMAX_MOD_MSB:PMAX_MOD_LSB], acc_in};
        if (take && op_in == PMAX_OP_STORE_ACC_TO_COUNTER_VIA_PROG
            && ppage == 3'(p))
          pc_nxt = {prog_r[PMAX_MOD_MSB:PMAX_MOD_LSB], acc_in};
        if (take && op_in == PMAX_OP_STORE_ACC_TO_POINTER_VIA_DATA
            && dpage == 3'(p))
          dp_nxt = {data_r[PMAX_MOD_MSB:PMAX_MOD_LSB], acc_in};
        if (take && op_in == PMAX_OP_STORE_ACC_TO_POINTER_VIA_PROG
            && ppage == 3'(p))
          dp_nxt = {prog_r[PMAX_MOD_MSB:PMAX_MOD_LSB], acc_in};
        // Wraps inside the page; the extension is never carried into
        if (state_r == PMAX_ST_FETCH && fext_r == 3'(p))
          pc_nxt = pc_r[p] + PMAX_OFS_ONE;
      end
      always_ff @(posedge core_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          pc_r[p] <= PMAX_OFS_RST;
          dp_r[p] <= PMAX_OFS_RST;
        end
        else
        begin
          pc_r[p] <= pc_nxt;
          dp_r[p] <= dp_nxt;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_fetch_page_ext: assert property (
    fetch_out |-> mem_addr_out[13:11] == $past(fext_r, 2))
    else $error("fetch page bad");
  a_pc_wraps_page: assert property ((state_r == PMAX_ST_FETCH) |=>
    pc_r[$past(fext_r)] == $past(pc_r[fext_r]) + PMAX_OFS_ONE)
    else $error("counter did not step in page");
  a_ext_mirror: assert property ((state_r == PMAX_ST_LATCH) |->
    fext_r == ppage) else $error("extension not mirrored");
  a_ext_late: assert property ((state_r != PMAX_ST_FETCH) |=>
    $stable(fext_r)) else $error("extension moved early");
  a_prefetch_old: assert property (
    (take && op_in == PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE) |->
    ##2 (fetch_out && mem_addr_out[13:11] == $past(fext_r, 2)))
    else $error("no old fetch");
  a_jump_to_new: assert property (
    (take && op_in == PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE) |->
    ##2 (fext_r == $past(acc_in[5:3], 2))) else $error("no page jump");
  a_counter_load: assert property (
    (take && op_in == PMAX_OP_STORE_ACC_TO_COUNTER_VIA_DATA_MODULE) |=>
    pc_r[dpage] == {data_r[2:0], $past(acc_in)})
    else $error("counter load wrong");
  a_ind_data_addr: assert property (
    (take && op_in == PMAX_OP_LOAD_IND_DATA) |=>
    (mem_rd_out && mem_addr_out == {dpage, dp_r[dpage]}))
    else $error("data addr wrong");
  a_ind_prog_addr: assert property (
    (take && op_in == PMAX_OP_LOAD_IND_PROG) |=>
    (mem_rd_out && mem_addr_out == {ppage, dp_r[ppage]}))
    else $error("prog addr wrong");
  a_fetch_then_ins: assert property (fetch_out |=>
    instr_valid_out) else $error("fetch not latched");

  c_page_switch: cover property (take &&
    op_in == PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE ##2 fetch_out);
  c_ind_store: cover property (mem_wr_out);
  c_counter_wrap: cover property (state_r == PMAX_ST_FETCH &&
    pc_r[fext_r] == 11'h7FF);
  c_acc_load: cover property (acc_load_out && $past(mem_rd_out));

endmodule

// ==== testbench/pmax_mem_model.sv ====
// Purpose: memory devices on the module bus, read answered in strobe cycle
// Assumes: contents start as a fixed pattern of the address
// Notes: undriven data lines show the inverse of their last value
module pmax_mem_model
(
  input wire logic clk_in,
  input wire logic [13:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16384];
  logic [7:0] last;
  initial
  begin
    for (int a = 0; a < 16384; a++)
      mem[a] = 8'(a) ^ 8'(a >> 8);
    last = 8'h00;
  end
  always @(posedge clk_in)
  begin
    if (wr_in)
      mem[addr_in] <= wdata_in;
    if (rd_in)
      last <= mem[addr_in];
  end
  // Stale data would hide a late strobe, so it is inverted
  assign rdata_out = rd_in ? mem[addr_in] : ~last;
endmodule

// ==== testbench/testbench.sv ====
// Purpose: random and corner operations against a page model
// Assumes: every instruction is one word, so any counter value is legal
// Notes: each operation is followed by a refused request while busy
module testbench
  import pmax_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, nrst_in, op_valid_in, ready_out, mem_rd_out;
  logic mem_wr_out, fetch_out, instr_valid_out, acc_load_out;
  pmax_op_t op_in;
  logic [7:0] acc_in, mem_rdata_in, mem_wdata_out, instr_out, acc_data_out;
  logic [7:0] program_module_out, data_module_out, pm, dm;
  logic [7:0] bm [16384];
  logic [10:0] jump_addr_in;
  logic [10:0] pc [8];
  logic [10:0] ptr [8];
  logic [13:0] mem_addr_out;
  logic [2:0] fetch_page_extension_out, ext;
  int miscompares, compares;
  pmax_core i_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .op_valid_in(op_valid_in), .op_in(op_in), .acc_in(acc_in),
    .jump_addr_in(jump_addr_in), .mem_rdata_in(mem_rdata_in),
    .ready_out(ready_out), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .fetch_out(fetch_out),
    .instr_out(instr_out), .instr_valid_out(instr_valid_out),
    .acc_data_out(acc_data_out), .acc_load_out(acc_load_out),
    .program_module_out(program_module_out),
    .data_module_out(data_module_out),
    .fetch_page_extension_out(fetch_page_extension_out));
  pmax_mem_model i_mem (.clk_in(core_clk_in), .addr_in(mem_addr_out),
    .rd_in(mem_rd_out), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
    .rdata_out(mem_rdata_in));
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  // ****
  // Checking and closing
  // ****
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic model_reset();
    pm = 8'h00;
    dm = 8'h00;
    ext = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      pc[i] = 11'h000;
      ptr[i] = 11'h000;
    end
  endtask
  // ****
  // One instruction: drive, watch, predict
  // ****
  task automatic do_op(pmax_op_t o, logic [7:0] a, logic [10:0] j);
    logic [13:0] fa, ra, wa;
    logic [7:0] ad, wd, ins;
    logic done;
    done = 1'b0;
    @(posedge core_clk_in);
    op_valid_in <= 1'b1;
    op_in <= o;
    acc_in <= a;
    jump_addr_in <= j;
    @(posedge core_clk_in);
    // A jump offered while busy must be ignored
    op_in <= PMAX_OP_JUMP;
    jump_addr_in <= 11'($urandom);
    for (int n = 0; n < 10 && !done; n++)
    begin
      @(negedge core_clk_in);
      if (mem_rd_out && fetch_out)
        fa = mem_addr_out;
      else if (mem_rd_out)
        ra = mem_addr_out;
      if (mem_wr_out)
      begin
        wa = mem_addr_out;
        wd = mem_wdata_out;
      end
      if (acc_load_out)
        ad = acc_data_out;
      if (n == 0)
        chk("busy", ready_out, 0);
      if (instr_valid_out)
      begin
        ins = instr_out;
        done = 1'b1;
        chk("ready", ready_out, 1);
      end
      @(posedge core_clk_in);
      op_valid_in <= 1'b0;
    end
    if (!done)
    begin
      chk("completion", 0, 1);
      tally_and_finish();
    end
    case (o)
      PMAX_OP_JUMP: pc[ext] = j;
      PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE: pm = a;
      PMAX_OP_STORE_ACC_TO_DATA_MODULE: dm = a;
      PMAX_OP_LOAD_ACC_FROM_DATA_MODULE: chk("acc", ad, dm);
      PMAX_OP_STORE_ACC_TO_POINTER_VIA_DATA: ptr[dm[5:3]] = {dm[2:0], a};
      PMAX_OP_STORE_ACC_TO_POINTER_VIA_PROG: ptr[pm[5:3]] = {pm[2:0], a};
      PMAX_OP_STORE_ACC_TO_COUNTER_VIA_DATA_MODULE:
        pc[dm[5:3]] = {dm[2:0], a};
      PMAX_OP_STORE_ACC_TO_COUNTER_VIA_PROG: pc[pm[5:3]] = {pm[2:0], a};
      PMAX_OP_LOAD_IND_PROG:
      begin
        chk("read addr", ra, {pm[5:3], ptr[pm[5:3]]});
        chk("acc", ad, bm[{pm[5:3], ptr[pm[5:3]]}]);
      end
      PMAX_OP_LOAD_IND_DATA:
      begin
        chk("read addr", ra, {dm[5:3], ptr[dm[5:3]]});
        chk("acc", ad, bm[{dm[5:3], ptr[dm[5:3]]}]);
      end
      PMAX_OP_STORE_IND_DATA:
      begin
        chk("write addr", wa, {dm[5:3], ptr[dm[5:3]]});
        chk("write data", wd, a);
        bm[{dm[5:3], ptr[dm[5:3]]}] = a;
      end
      default: ;
    endcase
    chk("fetch addr", fa, {ext, pc[ext]});
    chk("instr", ins, bm[{ext, pc[ext]}]);
    pc[ext] = pc[ext] + 11'h001;
    ext = pm[5:3];
    chk("extension", fetch_page_extension_out, ext);
    chk("program module", program_module_out, pm);
    chk("data module", data_module_out, dm);
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    nrst_in = 1'b0;
    op_valid_in = 1'b0;
    op_in = PMAX_OP_NONE;
    acc_in = 8'h00;
    jump_addr_in = 11'h000;
    miscompares = 0;
    compares = 0;
    model_reset();
    for (int a = 0; a < 16384; a++)
      bm[a] = 8'(a) ^ 8'(a >> 8);
    void'($urandom(32'hf8de));
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    @(negedge core_clk_in);
    chk("ready", ready_out, 1);
    $display("test reset done");
    do_op(PMAX_OP_JUMP, 8'h00, 11'h7FF);
    do_op(PMAX_OP_NONE, 8'h00, 11'h000);
    $display("test page wrap done");
    // Counter set up in page 5, then switch with a repeated store
    do_op(PMAX_OP_STORE_ACC_TO_DATA_MODULE, 8'h2D, 11'h000);
    do_op(PMAX_OP_STORE_ACC_TO_COUNTER_VIA_DATA_MODULE, 8'h40, 11'h000);
    do_op(PMAX_OP_LOAD_ACC_FROM_DATA_MODULE, 8'h00, 11'h000);
    do_op(PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE, 8'h2D, 11'h000);
    do_op(PMAX_OP_STORE_ACC_TO_PROGRAM_MODULE, 8'h2D, 11'h000);
    $display("test page change done");
    // Any jump target is an instruction start here
    for (int i = 0; i < 300; i++)
      do_op(pmax_op_t'(4'(i < 12 ? i : $urandom_range(11))),
        8'($urandom), 11'($urandom));
    $display("test random done");
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    @(negedge core_clk_in);
    model_reset();
    chk("extension", fetch_page_extension_out, ext);
    chk("data module", data_module_out, dm);
    chk("ready", ready_out, 1);
    chk("program module", program_module_out, pm);
    @(posedge core_clk_in);
    nrst_in <= 1'b1;
    do_op(PMAX_OP_NONE, 8'h00, 11'h000);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
